// >>> hw/dcd_pkg.sv
// shared constants and types
package dcd_pkg;
    localparam int CW            = 32;
    // controller command word fields
    localparam int FN_LO         = 0;
    localparam int IRQ_ALLOW_BIT = 6;
    localparam int IDLE_BIT      = 7;
    localparam int UNIT_LO       = 8;
    localparam int ATTN_LO       = 16;
    localparam int SSE_BLOCK_BIT = 22;
    localparam int SSE_CLR_BIT   = 23;
    localparam int DIAG_BIT      = 25;
    localparam int AUTO_SKIP_BIT = 27;
    localparam int WR_BLOCK_BIT  = 28;
    localparam int FORMAT_BIT    = 29;
    // device status word fields
    localparam int ST_TMO_BIT    = 0;
    localparam int ST_ERR_BIT    = 1;
    localparam int ST_PEND_BIT   = 2;
    // drive command word fields
    localparam int CART_MARK_BIT = 0;
    localparam int CART_GS_BIT   = 1;
    localparam int CART_DIR_BIT  = 2;
    localparam int CART_RST_BIT  = 3;
    localparam int CART_HEAD_BIT = 4;
    localparam int CART_DIFF_LO  = 7;
    localparam int CYL_ADDR_LO   = 0;
    localparam int CYL_FLAG_BIT  = 13;
    // word kinds on the command path
    localparam logic [1:0] KIND_CTRL = 2'h0;
    localparam logic [1:0] KIND_CART = 2'h1;
    localparam logic [1:0] KIND_CYL  = 2'h2;
    // host map and drive ops
    localparam logic [3:0] REG_CMD   = 4'h0;
    localparam logic [3:0] REG_DOP   = 4'h4;
    localparam logic [3:0] REG_STAT  = 4'h8;
    localparam logic [3:0] REG_DSTAT = 4'hc;
    localparam logic [1:0] OP_GET_STATUS = 2'h0;
    localparam logic [1:0] OP_CART_SEEK  = 2'h1;
    localparam logic [1:0] OP_CYL_SEEK   = 2'h2;
    localparam int DOP_DIR_BIT   = 4;
    localparam int DOP_HEAD_BIT  = 5;
    localparam int DOP_AMT_LO    = 16;
    // operation timeout
    localparam int CLK_MHZ       = 125;
    localparam int TIMEOUT_US    = 1000;
    localparam int TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
    typedef enum logic [3:0] {
        DCD_NOP, DCD_WR_CHECK, DCD_GET_STATUS, DCD_SEEK, DCD_RD_HEADER,
        DCD_WR_DATA, DCD_RD_DATA, DCD_RD_NOHDR, DCD_DIAG, DCD_FORMAT, DCD_BAD
    } dcd_func_e;
    typedef enum logic [1:0] {
        DCD_IDLE = 2'b00, DCD_RUN = 2'b01, DCD_DWORD = 2'b11, DCD_WSTAT = 2'b10
    } dcd_state_e;
endpackage

// >>> hw/dcd_if.sv
// command path between the two ends
`timescale 1ns/100ps
`default_nettype none
interface dcd_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic        cmd_valid;
    logic        cmd_ready;
    logic [1:0]  cmd_kind;
    logic [31:0] cmd_word;
    logic        stat_valid;
    logic [31:0] stat_word;
    logic [31:0] ctrl_status;
    logic        slow_bus_interrupt;
    modport dev (
        input  cmd_valid, cmd_kind, cmd_word,
        output cmd_ready, stat_valid, stat_word, ctrl_status, slow_bus_interrupt
    );
    modport host (
        output cmd_valid, cmd_kind, cmd_word,
        input  cmd_ready, stat_valid, stat_word, ctrl_status, slow_bus_interrupt
    );
endinterface
`default_nettype wire

// >>> hw/dcd_drive_word.sv
// drive command word builder
`timescale 1ns/100ps
`default_nettype none
module dcd_drive_word
    import dcd_pkg::*;
(
    input  wire logic [1:0]  op,
    input  wire logic        dir,
    input  wire logic        head,
    input  wire logic [9:0]  amount,
    output logic [31:0]      word,
    output logic [1:0]       kind,
    output logic             op_ok
);
    always_comb begin
        word  = 32'h0000_0000;
        kind  = KIND_CART;
        op_ok = 1'b1;
        case (op)
            OP_GET_STATUS: begin
                word[CART_MARK_BIT] = 1'b1; // [R13]
                word[CART_GS_BIT]   = 1'b1; // [R14]
                word[CART_RST_BIT]  = 1'b1; // [R15]
            end
            OP_CART_SEEK: begin
                word[CART_MARK_BIT] = 1'b1;
                word[CART_DIR_BIT]  = dir; // [R17]
                word[CART_HEAD_BIT] = head;
                word[CART_DIFF_LO +: 9] = amount[8:0];
            end
            OP_CYL_SEEK: begin
                kind = KIND_CYL;
                word[CYL_ADDR_LO +: 10] = amount; // [R18]
                word[CYL_FLAG_BIT]      = 1'b1;
            end
            default: op_ok = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// >>> hw/dcd_host.sv
// processor end: axi4-lite registers
`timescale 1ns/100ps
`default_nettype none
module dcd_host
    import dcd_pkg::*;
(
    input  wire logic  aclk,
    input  wire logic  aresetn,
    dcd_if.host        link,
    input  wire logic [3:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [3:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    output logic             irq
);
    import dcd_pkg::*;
    logic        aw_got, next_aw_got, w_got, next_w_got;
    logic [3:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic        bvalid, next_bvalid;
    logic [1:0]  bresp, next_bresp;
    logic        rvalid, next_rvalid;
    logic [1:0]  rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic        snd_valid, next_snd_valid;
    logic [1:0]  snd_kind, next_snd_kind;
    logic [31:0] snd_word, next_snd_word;
    logic [31:0] dstat, next_dstat;
    logic [31:0] bld_word;
    logic [1:0]  bld_kind;
    logic        bld_ok;

    dcd_drive_word u_word (
        .op     (w_data[1:0]),
        .dir    (w_data[DOP_DIR_BIT]),
        .head   (w_data[DOP_HEAD_BIT]),
        .amount (w_data[DOP_AMT_LO +: 10]),
        .word   (bld_word),
        .kind   (bld_kind),
        .op_ok  (bld_ok)
    );

    // one write in flight; a new one waits until the word has left
    assign s_awready = !aw_got && !bvalid && !snd_valid;
    assign s_wready  = !w_got && !bvalid && !snd_valid;
    assign s_arready = !rvalid;
    assign s_bvalid  = bvalid;
    assign s_bresp   = bresp;
    assign s_rvalid  = rvalid;
    assign s_rresp   = rresp;
    assign s_rdata   = rdata;
    assign irq       = link.slow_bus_interrupt;
    assign link.cmd_valid = snd_valid;
    assign link.cmd_kind  = snd_kind;
    assign link.cmd_word  = snd_word;

    always_comb begin
        next_aw_got = aw_got;  next_aw_addr = aw_addr;
        next_w_got  = w_got;   next_w_data  = w_data;
        next_bvalid = bvalid;  next_bresp   = bresp;
        next_snd_valid = snd_valid;
        next_snd_kind  = snd_kind;
        next_snd_word  = snd_word;
        next_dstat     = dstat;
        if (s_awvalid && s_awready) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            next_w_got  = 1'b1;
            next_w_data = s_wdata;
        end
        if (snd_valid && link.cmd_ready) begin
            next_snd_valid = 1'b0;
        end
        if (bvalid && s_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_got && w_got) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = 2'h0;
            if (aw_addr == REG_CMD) begin
                next_snd_valid = 1'b1; // [R19]
                next_snd_kind  = KIND_CTRL;
                next_snd_word  = w_data;
            end else if (aw_addr == REG_DOP && bld_ok) begin
                next_snd_valid = 1'b1;
                next_snd_kind  = bld_kind;
                next_snd_word  = bld_word;
            end else begin
                next_bresp = 2'h2;
            end
        end
        if (link.stat_valid) begin
            next_dstat = link.stat_word;
        end
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rresp  = rresp;
        next_rdata  = rdata;
        if (rvalid && s_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = 2'h0;
            next_rdata  = 32'h0000_0000;
            if (s_araddr == REG_STAT) begin
                next_rdata = {snd_valid, link.ctrl_status[30:0]};
            end else if (s_araddr == REG_DSTAT) begin
                next_rdata = dstat;
            end else if (s_araddr != REG_CMD && s_araddr != REG_DOP) begin
                next_rresp = 2'h2;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0; w_got <= 1'b0; bvalid <= 1'b0; bresp <= 2'h0;
            rvalid <= 1'b0; rresp <= 2'h0; snd_valid <= 1'b0; snd_kind <= KIND_CTRL;
            dstat <= 32'h0000_0000;
        end else begin
            aw_got <= next_aw_got; aw_addr <= next_aw_addr;
            w_got <= next_w_got; w_data <= next_w_data;
            bvalid <= next_bvalid; bresp <= next_bresp;
            rvalid <= next_rvalid; rresp <= next_rresp; rdata <= next_rdata;
            snd_valid <= next_snd_valid; snd_kind <= next_snd_kind;
            snd_word <= next_snd_word; dstat <= next_dstat;
        end
    end
endmodule
`default_nettype wire

// >>> hw/dcd_device.sv
// controller end: command word decode
// Operation
// R1 - three function bits select eight functions
// R2 - codes 000,001,010 are nop, check, status
// R3 - diagnostic bit with zero code: diagnostic
// R4 - format bit with zero code: format
// R5 - interrupt allowed only when allow bit set
// R6 - function starts only with idle flag clear
// R7 - two bits choose the drive unit
// R8 - attention bits clear matching status flags
// R9 - error block bit stops cylinder skip sectoring
// R10 - clear bit resets skip sector error flag
// R11 - auto skip sectoring unless block bit set
// R12 - write block stops writes and timeout
// R13 - processor sets marker in status request
// R14 - status bit asks cartridge drive for status
// R15 - reset bit clears drive errors first
// R16 - drive status word passed to processor
// R17 - cartridge seek: direction, count, head passed
// R18 - cylinder seek address passed to drive
// R19 - command word precedes every function
// R20 - interrupt on done, status change, error
`timescale 1ns/100ps
`default_nettype none
module dcd_device
    import dcd_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    dcd_if.dev               link,
    output logic [1:0]       unit_select,
    output dcd_func_e        func_code,
    output logic             func_start,
    output logic             write_block,
    output logic             auto_skip_enable,
    output logic             skip_sector_enable,
    input  wire logic        func_done,
    input  wire logic        func_error,
    input  wire logic [3:0]  attention_set,
    input  wire logic        sse_event,
    output logic             drive_word_valid,
    output logic [1:0]       drive_family,
    output logic [31:0]      drive_word,
    input  wire logic        drive_word_ready,
    input  wire logic        drive_stat_valid,
    input  wire logic [31:0] drive_stat_word
);
    import dcd_pkg::*;
    dcd_state_e  state, next_state;
    dcd_func_e   func, next_func;
    logic        start, next_start;
    logic [1:0]  unit, next_unit;
    logic        irq_allow, next_irq_allow;
    logic        wblock, next_wblock;
    logic        auto_blk, next_auto_blk;
    logic        sse_blk, next_sse_blk;
    logic [3:0]  attn, next_attn;
    logic        skip_sector_error_clear, next_skip_sector_error_clear;
    logic        pend, next_pend;
    logic        tmo, next_tmo;
    logic        err, next_err;
    logic [31:0] tcount, next_tcount;
    logic [1:0]  dfam, next_dfam;
    logic [31:0] dword, next_dword;
    logic        svalid, next_svalid;
    logic [31:0] sword, next_sword;
    logic        ctrl_take;
    logic        word_take;
    dcd_func_e   dec;

    // reserved combinations are refused
    function automatic dcd_func_e decode(input logic [31:0] w);
        logic [2:0] f;
        logic       d;
        logic       m;
        f = w[FN_LO +: 3];
        d = w[DIAG_BIT];
        m = w[FORMAT_BIT];
        if (f == 3'h0) begin
            if (d && !m) begin
                decode = DCD_DIAG; // [R3]
            end else if (m && !d) begin
                decode = DCD_FORMAT; // [R4]
            end else if (!d && !m) begin
                decode = DCD_NOP; // [R2]
            end else begin
                decode = DCD_BAD;
            end
        end else if (d || m) begin
            decode = DCD_BAD;
        end else begin
            case (f)
                3'h1:    decode = DCD_WR_CHECK; // [R2]
                3'h2:    decode = DCD_GET_STATUS;
                3'h3:    decode = DCD_SEEK; // [R1]
                3'h4:    decode = DCD_RD_HEADER;
                3'h5:    decode = DCD_WR_DATA;
                3'h6:    decode = DCD_RD_DATA;
                default: decode = DCD_RD_NOHDR;
            endcase
        end
    endfunction

    assign dec       = decode(link.cmd_word);
    assign ctrl_take = link.cmd_valid && state == DCD_IDLE && link.cmd_kind == KIND_CTRL;
    assign word_take = link.cmd_valid && state == DCD_IDLE && link.cmd_kind != KIND_CTRL;

    assign link.cmd_ready = state == DCD_IDLE;
    assign link.stat_valid = svalid;
    assign link.stat_word  = sword;
    assign link.slow_bus_interrupt = irq_allow && pend; // [R5]
    always_comb begin
        link.ctrl_status = 32'h0000_0000;
        link.ctrl_status[ST_TMO_BIT]  = tmo;
        link.ctrl_status[ST_ERR_BIT]  = err;
        link.ctrl_status[ST_PEND_BIT] = pend;
        link.ctrl_status[IDLE_BIT]    = state == DCD_IDLE;
        link.ctrl_status[UNIT_LO +: 2] = unit;
        link.ctrl_status[ATTN_LO +: 4] = attn;
        link.ctrl_status[SSE_CLR_BIT]  = skip_sector_error_clear;
    end

    assign unit_select        = unit;
    assign func_code          = func;
    assign func_start         = start;
    assign write_block        = wblock;
    assign auto_skip_enable   = !auto_blk; // [R11]
    assign skip_sector_enable = !sse_blk; // [R9]
    assign drive_word_valid   = state == DCD_DWORD;
    assign drive_family       = dfam;
    assign drive_word         = dword;

    // fields latched from each controller word
    always_comb begin
        next_func      = func;
        next_unit      = unit;
        next_irq_allow = irq_allow;
        next_wblock    = wblock;
        next_auto_blk  = auto_blk;
        next_sse_blk   = sse_blk;
        next_start     = 1'b0;
        if (ctrl_take) begin
            next_func      = dec;
            next_unit      = link.cmd_word[UNIT_LO +: 2]; // [R7]
            next_irq_allow = link.cmd_word[IRQ_ALLOW_BIT];
            next_wblock    = link.cmd_word[WR_BLOCK_BIT]; // [R12]
            next_auto_blk  = link.cmd_word[AUTO_SKIP_BIT];
            next_sse_blk   = link.cmd_word[SSE_BLOCK_BIT];
            next_start     = !link.cmd_word[IDLE_BIT] && dec != DCD_NOP
                             && dec != DCD_BAD; // [R6]
        end
    end

    // sticky flags: a new event in the clearing cycle survives
    always_comb begin
        next_attn     = attn;
        next_skip_sector_error_clear = skip_sector_error_clear;
        next_pend     = pend;
        if (ctrl_take) begin
            next_attn     = attn & ~link.cmd_word[ATTN_LO +: 4]; // [R8]
            next_skip_sector_error_clear = skip_sector_error_clear && !link.cmd_word[SSE_CLR_BIT]; // [R10]
            next_pend     = 1'b0;
        end
        next_attn = next_attn | attention_set;
        if (sse_event) begin
            next_skip_sector_error_clear = 1'b1;
        end
        if (|attention_set) begin
            next_pend = 1'b1; // [R20]
        end
        if (state == DCD_RUN && (func_done || func_error
            || (!wblock && tcount >= TIMEOUT_CYCLES - 1))) begin
            next_pend = 1'b1; // [R20]
        end
    end

    // function, drive word and status sequencing
    always_comb begin
        next_state  = state;
        next_tmo    = tmo;
        next_err    = err;
        next_tcount = 32'h0000_0000;
        next_dfam   = dfam;
        next_dword  = dword;
        next_svalid = 1'b0;
        next_sword  = sword;
        case (state)
            DCD_IDLE: begin
                if (ctrl_take) begin
                    next_tmo = 1'b0;
                    next_err = 1'b0;
                    if (next_start) begin
                        next_state = DCD_RUN;
                    end
                end else if (word_take) begin
                    next_dfam  = link.cmd_kind;
                    next_dword = link.cmd_word; // [R17] [R18]
                    next_state = DCD_DWORD;
                end
            end
            DCD_RUN: begin
                if (!wblock) begin
                    next_tcount = tcount + 32'h0000_0001; // [R12]
                end
                if (func_done) begin
                    next_state = DCD_IDLE;
                end else if (func_error) begin
                    next_err   = 1'b1;
                    next_state = DCD_IDLE;
                end else if (!wblock && tcount >= TIMEOUT_CYCLES - 1) begin
                    next_tmo   = 1'b1;
                    next_state = DCD_IDLE;
                end
            end
            DCD_DWORD: begin
                if (drive_word_ready) begin
                    if (dfam == KIND_CART && dword[CART_GS_BIT]) begin
                        next_state = DCD_WSTAT; // [R14]
                    end else begin
                        next_state = DCD_IDLE;
                    end
                end
            end
            default: begin
                if (drive_stat_valid) begin
                    next_sword  = drive_stat_word; // [R16]
                    next_svalid = 1'b1;
                    next_state  = DCD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= DCD_IDLE; func <= DCD_NOP; start <= 1'b0; unit <= 2'h0;
            irq_allow <= 1'b0; wblock <= 1'b0; auto_blk <= 1'b0; sse_blk <= 1'b0;
            attn <= 4'h0; skip_sector_error_clear <= 1'b0; pend <= 1'b0; tmo <= 1'b0; err <= 1'b0;
            tcount <= 32'h0000_0000; dfam <= KIND_CART; dword <= 32'h0000_0000;
            svalid <= 1'b0; sword <= 32'h0000_0000;
        end else begin
            state <= next_state; func <= next_func; start <= next_start;
            unit <= next_unit; irq_allow <= next_irq_allow; wblock <= next_wblock;
            auto_blk <= next_auto_blk; sse_blk <= next_sse_blk; attn <= next_attn;
            skip_sector_error_clear <= next_skip_sector_error_clear; pend <= next_pend; tmo <= next_tmo;
            err <= next_err; tcount <= next_tcount; dfam <= next_dfam;
            dword <= next_dword; svalid <= next_svalid; sword <= next_sword;
        end
    end
endmodule
`default_nettype wire

// >>> bench/dcd_assertions.sv
// concurrent checks on the command path
`timescale 1ns/100ps
`default_nettype none
module dcd_assertions
    import dcd_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        cmd_valid,
    input wire logic        cmd_ready,
    input wire logic [1:0]  cmd_kind,
    input wire logic [31:0] cmd_word,
    input wire logic        stat_valid,
    input wire logic [31:0] stat_word,
    input wire logic [31:0] ctrl_status,
    input wire logic        slow_bus_interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic take, ctl, go, allow, next_allow, gs_wait, next_gs_wait;
    assign take = cmd_valid && cmd_ready;
    assign ctl  = take && cmd_kind == KIND_CTRL;
    // zero code wants one of diag or format
    assign go = ctl && !cmd_word[IDLE_BIT] && ((cmd_word[2:0] != 3'h0)
        ? !(cmd_word[DIAG_BIT] || cmd_word[FORMAT_BIT]) : cmd_word[DIAG_BIT] ^ cmd_word[FORMAT_BIT]);
    always_comb begin
        next_allow   = ctl ? cmd_word[IRQ_ALLOW_BIT] : allow;
        next_gs_wait = stat_valid ? 1'b0 : gs_wait;
        if (take && cmd_kind == KIND_CART && cmd_word[CART_GS_BIT]) begin
            next_gs_wait = 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        allow   <= aresetn ? next_allow : 1'b0;
        gs_wait <= aresetn ? next_gs_wait : 1'b0;
    end
    AST_IRQ_ALLOW: assert property (slow_bus_interrupt == (allow && ctrl_status[ST_PEND_BIT]))
        else $error("irq mismatch");
    AST_UNIT: assert property (ctl |=> ctrl_status[9:8] == $past(cmd_word[9:8]))
        else $error("unit not latched");
    AST_ATTN: assert property (ctl |=> (ctrl_status[19:16] & $past(cmd_word[19:16])) == 4'h0)
        else $error("attention not cleared");
    AST_SSE_CLR: assert property (ctl && cmd_word[SSE_CLR_BIT] |=> !ctrl_status[23])
        else $error("skip_sector_error_clear not cleared");
    AST_NO_START: assert property (ctl && cmd_word[IDLE_BIT] |=> cmd_ready)
        else $error("started with idle set");
    AST_START: assert property (go |=> !cmd_ready)
        else $error("no start");
    AST_IDLE_BIT: assert property (ctrl_status[IDLE_BIT] == cmd_ready)
        else $error("idle bit mismatch");
    AST_HOLD: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word))
        else $error("word dropped early");
    AST_GS_WAIT: assert property (gs_wait && !stat_valid |-> !cmd_ready)
        else $error("ready during status wait");
    AST_STAT_PULSE: assert property (stat_valid |-> gs_wait ##1 !stat_valid)
        else $error("bad status pulse");
endmodule
`default_nettype wire

// >>> bench/dcd_tb.sv
// self-checking bench for both ends
`timescale 1ns/100ps
`default_nettype none
module disk_controller_command_decode_tb;
    import dcd_pkg::*;
    typedef struct packed { logic [31:0] w; dcd_func_e f; logic go; } dcd_row_s;
    logic aclk, aresetn, awv, wv, bready, arv, rready, awr, wr_rdy, bv, arr, rv, irq;
    logic [3:0] awa, ara, attn;
    logic [31:0] wd, rdata, dword, dsw, d;
    logic [1:0] bresp, rresp, unit_select, dfam;
    dcd_func_e fcode;
    logic fstart, wblk, askip, sskip, fdone, ferr, sse, dwv, dwr, dsv;
    int failures = 0;
    int checks_done = 0;
    bit s;
    dcd_row_s rows [13] = '{'{32'h0000_0000, DCD_NOP, 1'b0}, '{32'h0000_0141, DCD_WR_CHECK, 1'b1},
        '{32'h0000_0202, DCD_GET_STATUS, 1'b1}, '{32'h0800_0303, DCD_SEEK, 1'b1},
        '{32'h0040_0004, DCD_RD_HEADER, 1'b1}, '{32'h1000_0045, DCD_WR_DATA, 1'b1},
        '{32'h0000_0006, DCD_RD_DATA, 1'b1}, '{32'h0000_0047, DCD_RD_NOHDR, 1'b1},
        '{32'h0200_0000, DCD_DIAG, 1'b1}, '{32'h2000_0040, DCD_FORMAT, 1'b1},
        '{32'h2200_0000, DCD_BAD, 1'b0}, '{32'h0000_0083, DCD_SEEK, 1'b0},
        '{32'h0200_0001, DCD_BAD, 1'b0}};
    dcd_if dcd_if_inst (.aclk(aclk), .aresetn(aresetn));
    dcd_host dcd_host_inst (.aclk(aclk), .aresetn(aresetn), .link(dcd_if_inst.host),
        .s_awaddr(awa), .s_awvalid(awv), .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hf),
        .s_wvalid(wv), .s_wready(wr_rdy), .s_bresp(bresp), .s_bvalid(bv), .s_bready(bready),
        .s_araddr(ara), .s_arvalid(arv), .s_arready(arr), .s_rdata(rdata), .s_rresp(rresp),
        .s_rvalid(rv), .s_rready(rready), .irq(irq));
    dcd_device #(.TIMEOUT_CYCLES(20)) dcd_device_inst (.aclk(aclk), .aresetn(aresetn),
        .link(dcd_if_inst.dev), .unit_select(unit_select), .func_code(fcode), .func_start(fstart),
        .write_block(wblk), .auto_skip_enable(askip), .skip_sector_enable(sskip),
        .func_done(fdone), .func_error(ferr), .attention_set(attn), .sse_event(sse),
        .drive_word_valid(dwv), .drive_family(dfam), .drive_word(dword),
        .drive_word_ready(dwr), .drive_stat_valid(dsv), .drive_stat_word(dsw));
    dcd_assertions dcd_assertions_inst (.aclk(aclk), .aresetn(aresetn),
        .cmd_valid(dcd_if_inst.cmd_valid), .cmd_ready(dcd_if_inst.cmd_ready),
        .cmd_kind(dcd_if_inst.cmd_kind), .cmd_word(dcd_if_inst.cmd_word),
        .stat_valid(dcd_if_inst.stat_valid), .stat_word(dcd_if_inst.stat_word),
        .ctrl_status(dcd_if_inst.ctrl_status), .slow_bus_interrupt(dcd_if_inst.slow_bus_interrupt));
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic hang(input bit ok);
        if (!ok) begin
            failures++;
            $display("BAD %0t no answer", $time);
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] r);
        bit ta, tw, tb;
        tb = 0;
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            ta = awv && awr; tw = wv && wr_rdy; tb = bv;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (tb) break;
        end
        bready <= 1'b0;
        hang(tb);
        cmp(bresp, r);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        bit ta, tb;
        tb = 0;
        ara <= a; arv <= 1'b1; rready <= 1'b1;
        repeat (50) begin
            @(negedge aclk);
            ta = arv && arr; tb = rv; v = rdata;
            @(posedge aclk);
            if (ta) arv <= 1'b0;
            if (tb) break;
        end
        rready <= 1'b0;
        hang(tb);
    endtask
    task automatic wait_hi(input bit drv, output bit seen);
        seen = 0;
        repeat (12) begin
            @(negedge aclk);
            seen = drv ? dwv : fstart;
            if (seen) break;
        end
        @(posedge aclk);
    endtask
    task automatic pulse(input logic e);
        fdone <= !e; ferr <= e;
        @(posedge aclk);
        fdone <= 1'b0; ferr <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic dop(input logic [31:0] v, input logic [31:0] exp, input logic [1:0] fam);
        wr(REG_DOP, v, 2'h0);
        wait_hi(1, s);
        hang(s);
        cmp({dfam, dword}, {fam, exp});
        dwr <= 1'b1;
        @(posedge aclk);
        dwr <= 1'b0;
    endtask
    initial begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        {aresetn, awv, wv, bready, arv, rready, fdone, ferr, sse, dwr, dsv} = '0;
        {awa, ara, attn, wd, dsw} = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_STAT, d);
        cmp(d, 32'h0000_0080);
        foreach (rows[i]) begin
            wr(REG_CMD, rows[i].w, 2'h0);
            wait_hi(0, s);
            cmp(s, rows[i].go);
            cmp(fcode, rows[i].f);
            cmp(unit_select, rows[i].w[9:8]);
            cmp({wblk, askip, sskip}, {rows[i].w[28], !rows[i].w[27], !rows[i].w[22]});
            if (rows[i].go) begin
                pulse(1'b0);
                rd(REG_STAT, d);
                cmp({irq, d[ST_PEND_BIT]}, {rows[i].w[6], 1'b1});
            end
        end
        $display("end decode table");
        wr(REG_CMD, 32'h0000_0003, 2'h0);
        repeat (30) @(posedge aclk);
        rd(REG_STAT, d);
        cmp({d[7], d[0]}, 2'b11);
        wr(REG_CMD, 32'h1000_0003, 2'h0);
        repeat (30) @(posedge aclk);
        rd(REG_STAT, d);
        cmp(d[7], 1'b0);
        pulse(1'b1);
        rd(REG_STAT, d);
        cmp({d[7], d[1]}, 2'b11);
        $display("end timeout");
        attn <= 4'hf; sse <= 1'b1;
        @(posedge aclk);
        attn <= 4'h0; sse <= 1'b0;
        rd(REG_STAT, d);
        cmp({d[23], d[19:16]}, 5'h1f);
        wr(REG_CMD, 32'h0085_0080, 2'h0);
        rd(REG_STAT, d);
        cmp({d[23], d[19:16]}, 5'h0a);
        $display("end flag clears");
        dop(32'h0000_0000, 32'h0000_000b, KIND_CART);
        dsw <= 32'h0000_5a3c; dsv <= 1'b1;
        @(posedge aclk);
        dsv <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(REG_DSTAT, d);
        cmp(d, 32'h0000_5a3c);
        dop(32'h0005_0031, 32'h0000_0295, KIND_CART);
        dop(32'h03a5_0002, 32'h0000_23a5, KIND_CYL);
        wr(REG_DOP, 32'h0000_0003, 2'h2);
        @(posedge aclk);
        wr(REG_STAT, 32'h0000_0000, 2'h2);
        $display("end drive words");
        tally_and_finish();
    end
endmodule
`default_nettype wire
